// ===== design/dpph_port.sv
// two 8-bit peripheral ports with direction, output, input latch and handshake
// assumes bus synchronous to phase-2 clock, pins synchronised here and joined in testbench
//
// Summary of operation
// - direction bit zero input, one output
// - output line follows output register bit
// - writes to input lines only stored
// - port read returns input register, transparent default
// - latching captures port A at edge
// - reading latched port A makes it transparent
// - port A output lines read pin level
// - port B output lines read output register
// - latched port B reads last edge capture
// - handshake read/write A, write B
// - data ready edge sets port A flag
// - data taken is pulse or level low
// - level data taken released by data ready
// - device drives data ready on line two
// - data taken sets flag, releases ready
// - control registers choose modes and latching
// - open-drain low interrupt from enabled flags
`timescale 1ns/100ps
module dpph_port #(
  parameter int PORT_W = 8
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  // processor bus
  input wire dpph_pkg::dpph_bus_s BUS_I,
  output logic [7:0] DATA_O,
  output logic DATA_VALID_O,
  // port a pins
  input wire logic [PORT_W-1:0] PORT_A_PINS_I,
  output logic [PORT_W-1:0] PORT_A_PINS_O,
  output logic [PORT_W-1:0] PORT_A_PINS_OE_O,
  // port b pins
  input wire logic [PORT_W-1:0] PORT_B_PINS_I,
  output logic [PORT_W-1:0] PORT_B_PINS_O,
  output logic [PORT_W-1:0] PORT_B_PINS_OE_O,
  // control lines
  input wire logic PORT_A_CTL_IN_I,
  input wire logic PORT_A_CTL_IO_I,
  output logic PORT_A_CTL_IO_O,
  output logic PORT_A_CTL_IO_OE_O,
  input wire logic PORT_B_CTL_IN_I,
  input wire logic PORT_B_CTL_IO_I,
  output logic PORT_B_CTL_IO_O,
  output logic PORT_B_CTL_IO_OE_O,
  // open-drain interrupt request
  output logic IRQ_N_O,
  output logic IRQ_N_OE_O
);

  // elaboration check: bus is one byte wide
  if (PORT_W != 8) begin : g_bad_width
    $error("PORT_W must be 8");
  end

  // edge selection for a control input
  function automatic logic edge_hit(input logic rise, input logic cur, input logic prv);
    edge_hit = rise ? (cur & ~prv) : (~cur & prv);
  endfunction

  // access decode
  logic acc;
  logic rd;
  logic wr;
  logic pa_acc;
  logic pa_acc_hs;
  logic pb_acc;
  // access needs both selects active
  // chip select qualify
  assign acc = BUS_I.sel_high & ~BUS_I.sel_low_n;
  assign rd = acc & BUS_I.read;
  assign wr = acc & ~BUS_I.read;
  assign pa_acc_hs = acc & (BUS_I.register_select == dpph_pkg::REG_PA_DATA);
  assign pa_acc = pa_acc_hs | (acc & (BUS_I.register_select == dpph_pkg::REG_PA_DATA_NOHS));
  assign pb_acc = acc & (BUS_I.register_select == dpph_pkg::REG_PB_DATA);

  // synchronisers: stage one, stage two, previous
  logic [PORT_W-1:0] pa_s1, pa_s2, pb_s1, pb_s2;
  logic [3:0] ctl_s1, ctl_s2, ctl_prv;
  logic [PORT_W-1:0] next_pa_s1, next_pa_s2, next_pb_s1, next_pb_s2;
  logic [3:0] next_ctl_s1, next_ctl_s2, next_ctl_prv;

  // sync next values
  // two-flop sync
  always_comb begin
    next_pa_s1 = PORT_A_PINS_I;
    next_pa_s2 = pa_s1;
    next_pb_s1 = PORT_B_PINS_I;
    next_pb_s2 = pb_s1;
    next_ctl_s1 = {PORT_B_CTL_IO_I, PORT_B_CTL_IN_I, PORT_A_CTL_IO_I, PORT_A_CTL_IN_I};
    next_ctl_s2 = ctl_s1;
    next_ctl_prv = ctl_s2;
  end

  // sync registers
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pa_s1 <= '0;
      pa_s2 <= '0;
      pb_s1 <= '0;
      pb_s2 <= '0;
      ctl_s1 <= 4'hF;
      ctl_s2 <= 4'hF;
      ctl_prv <= 4'hF;
    end else begin
      pa_s1 <= next_pa_s1;
      pa_s2 <= next_pa_s2;
      pb_s1 <= next_pb_s1;
      pb_s2 <= next_pb_s2;
      ctl_s1 <= next_ctl_s1;
      ctl_s2 <= next_ctl_s2;
      ctl_prv <= next_ctl_prv;
    end
  end

  // software registers
  logic [PORT_W-1:0] pa_dir, pb_dir, pa_out, pb_out;
  logic [7:0] aux_ctl, hs_ctl, ier;
  logic [PORT_W-1:0] next_pa_dir, next_pb_dir, next_pa_out, next_pb_out;
  logic [7:0] next_aux_ctl, next_hs_ctl, next_ier;

  // register writes
  // data, direction and control registers
  always_comb begin
    next_pa_dir = pa_dir;
    next_pb_dir = pb_dir;
    next_pa_out = pa_out;
    next_pb_out = pb_out;
    next_aux_ctl = aux_ctl;
    next_hs_ctl = hs_ctl;
    next_ier = ier;
    if (wr) begin
      unique case (BUS_I.register_select)
        dpph_pkg::REG_PB_DATA: next_pb_out = BUS_I.wdata;
        dpph_pkg::REG_PA_DATA, dpph_pkg::REG_PA_DATA_NOHS: next_pa_out = BUS_I.wdata;
        dpph_pkg::REG_PB_DIR: next_pb_dir = BUS_I.wdata;
        dpph_pkg::REG_PA_DIR: next_pa_dir = BUS_I.wdata;
        dpph_pkg::REG_AUX_CTL: next_aux_ctl = BUS_I.wdata;
        dpph_pkg::REG_HS_CTL: next_hs_ctl = BUS_I.wdata;
        dpph_pkg::REG_IER: begin
          if (BUS_I.wdata[dpph_pkg::IER_SET]) begin
            next_ier = ier | {1'b0, BUS_I.wdata[6:0]};
          end else begin
            next_ier = ier & ~{1'b0, BUS_I.wdata[6:0]};
          end
        end
        default: ;
      endcase
    end
  end

  // register storage
  // reset to inputs
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pa_dir <= '0;
      pb_dir <= '0;
      pa_out <= '0;
      pb_out <= '0;
      aux_ctl <= dpph_pkg::RST_REG;
      hs_ctl <= dpph_pkg::RST_REG;
      ier <= dpph_pkg::RST_REG;
    end else begin
      pa_dir <= next_pa_dir;
      pb_dir <= next_pb_dir;
      pa_out <= next_pa_out;
      pb_out <= next_pb_out;
      aux_ctl <= next_aux_ctl;
      hs_ctl <= next_hs_ctl;
      ier <= next_ier;
    end
  end

  // mode fields and control edges
  logic [2:0] ca2_mode, cb2_mode;
  logic ca1_edge, ca2_edge, cb1_edge, cb2_edge;
  logic pa_latch_en, pb_latch_en;
  assign ca2_mode = hs_ctl[dpph_pkg::HS_CA2_LO +: dpph_pkg::HS_MODE_W];
  assign cb2_mode = hs_ctl[dpph_pkg::HS_CB2_LO +: dpph_pkg::HS_MODE_W];
  assign pa_latch_en = aux_ctl[dpph_pkg::AUX_PA_LATCH];
  assign pb_latch_en = aux_ctl[dpph_pkg::AUX_PB_LATCH];
  assign ca1_edge = edge_hit(hs_ctl[dpph_pkg::HS_CA1_EDGE], ctl_s2[0], ctl_prv[0]);
  assign cb1_edge = edge_hit(hs_ctl[dpph_pkg::HS_CB1_EDGE], ctl_s2[2], ctl_prv[2]);
  // input edges count only while the line is an input
  assign ca2_edge = ~ca2_mode[2] & edge_hit(ca2_mode[1], ctl_s2[1], ctl_prv[1]);
  assign cb2_edge = ~cb2_mode[2] & edge_hit(cb2_mode[1], ctl_s2[3], ctl_prv[3]);

  // input latches, flags and handshake outputs
  logic [PORT_W-1:0] pa_hold, pb_hold, next_pa_hold, next_pb_hold;
  logic pa_latched, next_pa_latched;
  logic [6:0] interrupt_flag_reg, next_ifr, ifr_set, ifr_clr;
  logic ca2_out, cb2_out, next_ca2_out, next_cb2_out;

  always_comb begin
    next_pa_hold = pa_hold;
    next_pb_hold = pb_hold;
    next_pa_latched = pa_latched;
    if (rd && pa_acc) begin
      next_pa_latched = 1'b0;
    end
    if (pa_latch_en && ca1_edge) begin
      next_pa_hold = pa_s2;
      next_pa_latched = 1'b1;
    end
    if (pb_latch_en && cb1_edge) begin
      next_pb_hold = pb_s2;
    end
    // flag events and clears, set wins
    // control line edge flags
    ifr_set = '0;
    ifr_set[dpph_pkg::IF_CA1] = ca1_edge;
    ifr_set[dpph_pkg::IF_CA2] = ca2_edge;
    ifr_set[dpph_pkg::IF_CB1] = cb1_edge;
    ifr_set[dpph_pkg::IF_CB2] = cb2_edge;
    ifr_clr = '0;
    if (wr && BUS_I.register_select == dpph_pkg::REG_IFR) begin
      ifr_clr = BUS_I.wdata[6:0];
    end
    if (pa_acc) begin
      ifr_clr[dpph_pkg::IF_CA1] = 1'b1;
      ifr_clr[dpph_pkg::IF_CA2] = ifr_clr[dpph_pkg::IF_CA2] | (ca2_mode != dpph_pkg::MODE_IN_NEG_IND
        && ca2_mode != dpph_pkg::MODE_IN_POS_IND);
    end
    if (pb_acc) begin
      ifr_clr[dpph_pkg::IF_CB1] = 1'b1;
      ifr_clr[dpph_pkg::IF_CB2] = ifr_clr[dpph_pkg::IF_CB2] | (cb2_mode != dpph_pkg::MODE_IN_NEG_IND
        && cb2_mode != dpph_pkg::MODE_IN_POS_IND);
    end
    next_ifr = (interrupt_flag_reg & ~ifr_clr) | ifr_set;
    // port a line two: read and write handshake
    next_ca2_out = ca2_out;
    unique case (ca2_mode)
      dpph_pkg::MODE_OUT_HS: begin
        if (ca1_edge) begin
          next_ca2_out = 1'b1;
        end
        if (pa_acc_hs) begin
          next_ca2_out = 1'b0;
        end
      end
      dpph_pkg::MODE_OUT_PULSE: next_ca2_out = ~pa_acc_hs;
      dpph_pkg::MODE_OUT_LOW: next_ca2_out = 1'b0;
      default: next_ca2_out = dpph_pkg::RST_CTL_OUT;
    endcase
    // port b line two: write handshake only
    // b handshakes on writes
    next_cb2_out = cb2_out;
    unique case (cb2_mode)
      dpph_pkg::MODE_OUT_HS: begin
        if (cb1_edge) begin
          next_cb2_out = 1'b1;
        end
        if (pb_acc && wr) begin
          next_cb2_out = 1'b0;
        end
      end
      dpph_pkg::MODE_OUT_PULSE: next_cb2_out = ~(pb_acc && wr);
      dpph_pkg::MODE_OUT_LOW: next_cb2_out = 1'b0;
      default: next_cb2_out = dpph_pkg::RST_CTL_OUT;
    endcase
  end

  // latch, flag and handshake storage
  // idle high lines
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pa_hold <= '0;
      pb_hold <= '0;
      pa_latched <= 1'b0;
      interrupt_flag_reg <= '0;
      ca2_out <= dpph_pkg::RST_CTL_OUT;
      cb2_out <= dpph_pkg::RST_CTL_OUT;
    end else begin
      pa_hold <= next_pa_hold;
      pb_hold <= next_pb_hold;
      pa_latched <= next_pa_latched;
      interrupt_flag_reg <= next_ifr;
      ca2_out <= next_ca2_out;
      cb2_out <= next_cb2_out;
    end
  end

  // read views of the ports
  logic [PORT_W-1:0] pa_view, pb_view;
  logic any_irq;
  assign pa_view = (pa_latch_en && pa_latched) ? pa_hold : pa_s2;
  assign pb_view = (pb_dir & pb_out) | (~pb_dir & (pb_latch_en ? pb_hold : pb_s2));
  assign any_irq = |(interrupt_flag_reg & ier[6:0]);

  // read data register
  logic [7:0] rdata, next_rdata;
  logic rvalid, next_rvalid;
  always_comb begin
    next_rdata = rdata;
    next_rvalid = rd;
    if (rd) begin
      unique case (BUS_I.register_select)
        dpph_pkg::REG_PB_DATA: next_rdata = pb_view;
        dpph_pkg::REG_PA_DATA, dpph_pkg::REG_PA_DATA_NOHS: next_rdata = pa_view;
        dpph_pkg::REG_PB_DIR: next_rdata = pb_dir;
        dpph_pkg::REG_PA_DIR: next_rdata = pa_dir;
        dpph_pkg::REG_AUX_CTL: next_rdata = aux_ctl;
        dpph_pkg::REG_HS_CTL: next_rdata = hs_ctl;
        dpph_pkg::REG_IFR: next_rdata = {any_irq, interrupt_flag_reg};
        dpph_pkg::REG_IER: next_rdata = {1'b1, ier[6:0]};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // pin drive
  // per-line direction
  assign PORT_A_PINS_O = pa_out;
  assign PORT_A_PINS_OE_O = pa_dir;
  assign PORT_B_PINS_O = pb_out;
  assign PORT_B_PINS_OE_O = pb_dir;
  assign PORT_A_CTL_IO_O = ca2_out;
  assign PORT_A_CTL_IO_OE_O = ca2_mode[2];
  assign PORT_B_CTL_IO_O = cb2_out;
  assign PORT_B_CTL_IO_OE_O = cb2_mode[2];
  assign DATA_O = rdata;
  assign DATA_VALID_O = rvalid;
  // open drain: pull low while any enabled flag stands
  // wire-or interrupt
  assign IRQ_N_O = 1'b0;
  assign IRQ_N_OE_O = any_irq;

endmodule

// ===== include/dpph_pkg.sv
// package for the dual parallel port with handshake lines
// assumes one phase-2 clock and a processor bus sampled on its edge
package dpph_pkg;
  // register select codes
  localparam logic [3:0] REG_PB_DATA = 4'h0;
  localparam logic [3:0] REG_PA_DATA = 4'h1;
  localparam logic [3:0] REG_PB_DIR = 4'h2;
  localparam logic [3:0] REG_PA_DIR = 4'h3;
  localparam logic [3:0] REG_AUX_CTL = 4'hB;
  localparam logic [3:0] REG_HS_CTL = 4'hC;
  localparam logic [3:0] REG_IFR = 4'hD;
  localparam logic [3:0] REG_IER = 4'hE;
  localparam logic [3:0] REG_PA_DATA_NOHS = 4'hF;
  // handshake control fields
  localparam int HS_CA1_EDGE = 0;
  localparam int HS_CA2_LO = 1;
  localparam int HS_CB1_EDGE = 4;
  localparam int HS_CB2_LO = 5;
  localparam int HS_MODE_W = 3;
  // control line io modes (bit 2 high means output)
  localparam logic [2:0] MODE_IN_NEG = 3'h0;
  localparam logic [2:0] MODE_IN_NEG_IND = 3'h1;
  localparam logic [2:0] MODE_IN_POS = 3'h2;
  localparam logic [2:0] MODE_IN_POS_IND = 3'h3;
  localparam logic [2:0] MODE_OUT_HS = 3'h4;
  localparam logic [2:0] MODE_OUT_PULSE = 3'h5;
  localparam logic [2:0] MODE_OUT_LOW = 3'h6;
  localparam logic [2:0] MODE_OUT_HIGH = 3'h7;
  // auxiliary control fields
  localparam int AUX_PA_LATCH = 0;
  localparam int AUX_PB_LATCH = 1;
  // interrupt flag positions
  localparam int IF_CA2 = 0;
  localparam int IF_CA1 = 1;
  localparam int IF_CB2 = 3;
  localparam int IF_CB1 = 4;
  localparam int IF_ANY = 7;
  localparam int IER_SET = 7;
  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic RST_CTL_OUT = 1'b1;
  // processor access carrier
  typedef struct packed {
    logic sel_high;
    logic sel_low_n;
    logic [3:0] register_select;
    logic read;
    logic [7:0] wdata;
  } dpph_bus_s;
endpackage

// ===== tb/dpph_periph.sv
// peripheral model: data source on port a, write answerer on port b
// assumes line two of each port has a pull-up; pins are resolved here
`timescale 1ns/100ps
module dpph_periph (
  // clock and bench controls
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic a_go_i,
  input wire logic [7:0] a_data_i,
  input wire logic [3:0] delay_i,
  // device drive
  input wire logic [7:0] pa_o_i, pa_oe_i, pb_o_i, pb_oe_i,
  input wire logic ca2_o_i, ca2_oe_i, cb2_o_i, cb2_oe_i,
  // resolved wires
  output logic [7:0] pa_w_o, pb_w_o, b_ext_o,
  output logic ca1_o, cb1_o, ca2_w_o, cb2_w_o
);
  logic [7:0] a_ext;
  logic cb2_d;
  int ac, bc;
  // wire levels from both parties
  assign pa_w_o = (pa_oe_i & pa_o_i) | (~pa_oe_i & a_ext);
  assign pb_w_o = (pb_oe_i & pb_o_i) | (~pb_oe_i & b_ext_o);
  assign ca2_w_o = ca2_oe_i ? ca2_o_i : 1'b1;
  assign cb2_w_o = cb2_oe_i ? cb2_o_i : 1'b1;
  // handshake sequencing
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a_ext <= 8'h00; b_ext_o <= 8'h96; ca1_o <= 1'b1; cb1_o <= 1'b1;
      ac <= 0; bc <= 0; cb2_d <= 1'b1;
    end else begin
      cb2_d <= cb2_w_o;
      // data then ready edge, new data after taken
      if (a_go_i) begin a_ext <= a_data_i; ac <= 1; end
      else if (ac > 0 && ac < 6) ac <= ac + 1;
      ca1_o <= !(ac >= 3 && ac < 6);
      if (!ca2_w_o && ac == 6) begin a_ext <= ~a_ext; ac <= 0; end
      if (cb2_d && !cb2_w_o && bc == 0) bc <= 1;
      else if (bc > 0) bc <= (bc == int'(delay_i) + 4) ? 0 : bc + 1;
      cb1_o <= !(bc > int'(delay_i) && bc <= int'(delay_i) + 3);
      if (bc == int'(delay_i) + 4) b_ext_o <= ~b_ext_o;
    end
  end
endmodule

// ===== tb/dpph_port_test.sv
// self-checking bench for the dual parallel port with handshake lines
// assumes the peripheral model on the pins and a checker bound to the design
`timescale 1ns/100ps
module dpph_port_test;
  logic clk, rstn, a_go, ca1, cb1, ca2_w, cb2_w, ca2_o, ca2_oe, cb2_o, cb2_oe, irq_oe, dv;
  logic [3:0] dly;
  logic [7:0] a_data, dout, rdat, pa_w, pb_w, pa_o, pa_oe, pb_o, pb_oe, b_ext, rec;
  logic [31:0] lfsr;
  dpph_pkg::dpph_bus_s bus;
  int fail_count, n_checks, i, port_a_output_reg, port_b_output_reg, dda, ddb;
  dpph_port dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .BUS_I(bus), .DATA_O(dout), .DATA_VALID_O(dv),
    .PORT_A_PINS_I(pa_w), .PORT_A_PINS_O(pa_o), .PORT_A_PINS_OE_O(pa_oe),
    .PORT_B_PINS_I(pb_w), .PORT_B_PINS_O(pb_o), .PORT_B_PINS_OE_O(pb_oe),
    .PORT_A_CTL_IN_I(ca1), .PORT_A_CTL_IO_I(ca2_w), .PORT_A_CTL_IO_O(ca2_o),
    .PORT_A_CTL_IO_OE_O(ca2_oe), .PORT_B_CTL_IN_I(cb1), .PORT_B_CTL_IO_I(cb2_w),
    .PORT_B_CTL_IO_O(cb2_o), .PORT_B_CTL_IO_OE_O(cb2_oe), .IRQ_N_O(), .IRQ_N_OE_O(irq_oe));
  dpph_periph u_periph (.clk_i(clk), .rstn_i(rstn), .a_go_i(a_go), .a_data_i(a_data),
    .delay_i(dly), .pa_o_i(pa_o), .pa_oe_i(pa_oe), .pb_o_i(pb_o), .pb_oe_i(pb_oe),
    .ca2_o_i(ca2_o), .ca2_oe_i(ca2_oe), .cb2_o_i(cb2_o), .cb2_oe_i(cb2_oe), .pa_w_o(pa_w),
    .pb_w_o(pb_w), .b_ext_o(b_ext), .ca1_o(ca1), .cb1_o(cb1), .ca2_w_o(ca2_w), .cb2_w_o(cb2_w));
  // clock generator
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one access with both selects active
  task automatic acc(input logic rd, input logic [3:0] rs, input logic [7:0] wd);
    @(posedge clk) bus <= '{1'b1, 1'b0, rs, rd, wd};
    @(posedge clk) bus <= '{1'b0, 1'b1, 4'h0, 1'b1, 8'h00};
    #1 rdat = dout;
    if (rd) chk("valid", {7'h0, dv}, 8'h01);
  endtask
  task automatic rd_chk(input logic [3:0] rs, input logic [7:0] exp, input string nm);
    acc(1'b1, rs, 8'h00);
    chk(nm, rdat, exp);
  endtask
  task automatic go_a(input logic [7:0] d);
    @(posedge clk) begin a_go <= 1'b1; a_data <= d; end
    @(posedge clk) a_go <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    rstn = 1'b0; a_go = 1'b0; a_data = 8'h00; dly = 4'h1; lfsr = 32'h567624E5;
    bus = '{1'b0, 1'b1, 4'h0, 1'b1, 8'h00};
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(dpph_pkg::REG_PA_DIR, 8'h00, "dir_a");
    rd_chk(dpph_pkg::REG_PB_DIR, 8'h00, "dir_b");
    rd_chk(4'h5, 8'h00, "unmapped");
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      port_a_output_reg = lfsr[7:0]; port_b_output_reg = lfsr[15:8]; dda = lfsr[23:16]; ddb = lfsr[31:24];
      acc(1'b0, dpph_pkg::REG_PA_DIR, 8'h00);
      acc(1'b0, dpph_pkg::REG_PA_DATA_NOHS, port_a_output_reg[7:0]);
      acc(1'b0, dpph_pkg::REG_PB_DATA, port_b_output_reg[7:0]);
      chk("pins_a_in", pa_w, 8'h00);
      acc(1'b0, dpph_pkg::REG_PA_DIR, dda[7:0]);
      acc(1'b0, dpph_pkg::REG_PB_DIR, ddb[7:0]);
      chk("oe_a", pa_oe, dda[7:0]);
      chk("pins_a", pa_w, 8'((port_a_output_reg & dda)));
      repeat (3) @(posedge clk);
      rd_chk(dpph_pkg::REG_PA_DATA_NOHS, 8'(port_a_output_reg & dda), "read_a");
      rd_chk(dpph_pkg::REG_PB_DATA, 8'((port_b_output_reg & ddb) | (8'h96 & ~ddb)), "read_b");
    end
    $display("direction test done");
    acc(1'b0, dpph_pkg::REG_HS_CTL, 8'h88);
    acc(1'b0, dpph_pkg::REG_AUX_CTL, 8'h03);
    acc(1'b0, dpph_pkg::REG_IER, 8'h92);
    acc(1'b0, dpph_pkg::REG_IFR, 8'h7F);
    acc(1'b0, dpph_pkg::REG_PA_DIR, 8'hF0);
    acc(1'b0, dpph_pkg::REG_PA_DATA_NOHS, 8'h30);
    go_a(8'h5A);
    rd_chk(dpph_pkg::REG_IFR, 8'h82, "flag_a");
    chk("irq", {7'h0, irq_oe}, 8'h01);
    acc(1'b0, dpph_pkg::REG_PA_DATA, 8'hC0);
    repeat (4) @(posedge clk);
    chk("taken_low", {7'h0, ca2_w}, 8'h00);
    rd_chk(dpph_pkg::REG_PA_DATA, 8'h3A, "latched_a");
    repeat (4) @(posedge clk);
    rd_chk(dpph_pkg::REG_PA_DATA_NOHS, 8'hC5, "open_a");
    go_a(8'h0C);
    chk("taken_free", {7'h0, ca2_w}, 8'h01);
    $display("read handshake test done");
    acc(1'b0, dpph_pkg::REG_PB_DIR, 8'h0F);
    acc(1'b0, dpph_pkg::REG_IFR, 8'h7F);
    for (i = 0; i < 4; i++) begin
      acc(1'b0, dpph_pkg::REG_HS_CTL,
          {(i < 2) ? dpph_pkg::MODE_OUT_HS : dpph_pkg::MODE_OUT_PULSE, 5'h08});
      @(posedge clk) dly <= i[0] ? 4'hC : 4'h1;
      rec = b_ext;
      lfsr = nxt(lfsr);
      port_b_output_reg = lfsr[7:0];
      acc(1'b0, dpph_pkg::REG_PB_DATA, port_b_output_reg[7:0]);
      chk("ready_low", {7'h0, cb2_w}, 8'h00);
      for (int k = 0; k < 60 && irq_oe !== 1'b1; k++) @(posedge clk);
      rd_chk(dpph_pkg::REG_IFR, 8'h90, "flag_b");
      chk("ready_free", {7'h0, cb2_w}, 8'h01);
      rd_chk(dpph_pkg::REG_PB_DATA, 8'((port_b_output_reg & 8'h0F) | (rec & 8'hF0)), "latched_b");
      chk("read_no_hs", {7'h0, cb2_w}, 8'h01);
      rd_chk(dpph_pkg::REG_IFR, 8'h00, "flag_clear");
    end
    for (i = 6; i < 8; i++) begin
      acc(1'b0, dpph_pkg::REG_HS_CTL, {i[2:0], 5'h08});
      repeat (2) @(posedge clk);
      chk("fixed_level", {7'h0, cb2_w}, {7'h0, i[0]});
    end
    $display("write handshake test done");
    end_of_test();
  end
endmodule

// ===== tb/dpph_properties.sv
// checker for the dual port: bus answers, pin drive and line-two handshake
// assumes it is bound to dpph_port and sees only that module's ports
`timescale 1ns/100ps
module dpph_properties (
  // clock, reset and bus
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire dpph_pkg::dpph_bus_s BUS_I,
  input wire logic DATA_VALID_O,
  // pins and lines
  input wire logic [7:0] PORT_A_PINS_OE_O,
  input wire logic [7:0] PORT_B_PINS_O,
  input wire logic [7:0] PORT_B_PINS_OE_O,
  input wire logic PORT_A_CTL_IO_O,
  input wire logic PORT_B_CTL_IO_O,
  input wire logic PORT_B_CTL_IO_OE_O,
  input wire logic IRQ_N_O
);
  logic acc, wr, rd;
  logic [2:0] b_mode;
  // decoded access strobes
  assign acc = BUS_I.sel_high && !BUS_I.sel_low_n;
  assign wr = acc && !BUS_I.read;
  assign rd = acc && BUS_I.read;
  // shadow of the port b line-two mode
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      b_mode <= 3'h0;
    end else if (wr && BUS_I.register_select == dpph_pkg::REG_HS_CTL) begin
      b_mode <= BUS_I.wdata[7:5];
    end
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  sequence b_write_s;
    wr && BUS_I.register_select == dpph_pkg::REG_PB_DATA;
  endsequence
  sequence b_pulse_s;
    b_write_s ##0 (b_mode == dpph_pkg::MODE_OUT_PULSE) ##1 !acc;
  endsequence
  a_read_answer: assert property (rd |=> DATA_VALID_O)
    else $error("read not answered next cycle");
  a_valid_cause: assert property (!rd |=> !DATA_VALID_O)
    else $error("read data marked without a read");
  a_dir_a_oe: assert property (wr && BUS_I.register_select == dpph_pkg::REG_PA_DIR
    |=> PORT_A_PINS_OE_O == $past(BUS_I.wdata)) else $error("port a enables wrong");
  a_dir_b_oe: assert property (wr && BUS_I.register_select == dpph_pkg::REG_PB_DIR
    |=> PORT_B_PINS_OE_O == $past(BUS_I.wdata)) else $error("port b enables wrong");
  a_out_b_value: assert property (b_write_s |=> PORT_B_PINS_O == $past(BUS_I.wdata))
    else $error("port b output value wrong");
  a_irq_drain: assert property (IRQ_N_O == 1'b0)
    else $error("interrupt pin drives high");
  a_ready_low: assert property (b_write_s ##0 (b_mode[2:1] == 2'b10)
    |=> !PORT_B_CTL_IO_O && PORT_B_CTL_IO_OE_O) else $error("data ready not driven low");
  a_pulse_one: assert property (b_pulse_s |=> PORT_B_CTL_IO_O)
    else $error("pulse longer than one cycle");
  a_reset_idle: assert property ($rose(RSTN_I) |-> PORT_A_PINS_OE_O == 8'h00
    && PORT_A_CTL_IO_O) else $error("not idle after reset");
endmodule
bind dpph_port dpph_properties u_props (.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .BUS_I(BUS_I),
  .DATA_VALID_O(DATA_VALID_O), .PORT_A_PINS_OE_O(PORT_A_PINS_OE_O),
  .PORT_B_PINS_O(PORT_B_PINS_O), .PORT_B_PINS_OE_O(PORT_B_PINS_OE_O),
  .PORT_A_CTL_IO_O(PORT_A_CTL_IO_O), .PORT_B_CTL_IO_O(PORT_B_CTL_IO_O),
  .PORT_B_CTL_IO_OE_O(PORT_B_CTL_IO_OE_O), .IRQ_N_O(IRQ_N_O));
